// ---- core/bnr_regs.svh ----
`ifndef BNR_REGS_SVH
`define BNR_REGS_SVH

// Clock register window: top eight bytes of the address space
`define BNR_CLK_BASE_HI 16'hFFFF
`define BNR_ADDR_CENTURY 19'h7FFF8
`define BNR_ADDR_SECONDS 19'h7FFF9
`define BNR_ADDR_MINUTES 19'h7FFFA
`define BNR_ADDR_HOURS 19'h7FFFB
`define BNR_ADDR_WEEKDAY 19'h7FFFC
`define BNR_ADDR_DATE 19'h7FFFD
`define BNR_ADDR_MONTH 19'h7FFFE
`define BNR_ADDR_YEAR 19'h7FFFF

// Register indices (low three address bits)
`define BNR_IDX_CENT 3'h0
`define BNR_IDX_SEC 3'h1
`define BNR_IDX_MIN 3'h2
`define BNR_IDX_HOUR 3'h3
`define BNR_IDX_DAY 3'h4
`define BNR_IDX_DATE 3'h5
`define BNR_IDX_MON 3'h6
`define BNR_IDX_YEAR 3'h7

// Control and flag bit positions
`define BNR_BIT_WRITE 7
`define BNR_BIT_READ 6
`define BNR_BIT_OSC_STOP 7
`define BNR_BIT_BATT_GOOD 7
`define BNR_BIT_FREQ_TEST 6
`define BNR_BIT_FT_LSB 0

// Counting fields of each register; other bits are plain storage
`define BNR_MASK_CENT 8'h3F
`define BNR_MASK_SEC 8'h7F
`define BNR_MASK_MIN 8'h7F
`define BNR_MASK_HOUR 8'h3F
`define BNR_MASK_DAY 8'h07
`define BNR_MASK_DATE 8'h3F
`define BNR_MASK_MON 8'h1F
`define BNR_MASK_YEAR 8'hFF

// Reset image, index 7 (year) down to index 0 (century)
`define BNR_RESET_IMAGE 64'h00_01_01_01_00_00_00_00

// Timing: oscillator tick rate and the frequency test rate
`define BNR_OSC_TICK_HZ 1024
`define BNR_FREQ_TEST_HZ 512
`define BNR_TICKS_PER_SEC (`BNR_OSC_TICK_HZ)
// Address access time and its cycle count at 10 MHz (rounded down)
`define BNR_CLK_MHZ 10
`define BNR_ADDR_ACCESS_NS 100
`define BNR_ADDR_ACCESS_CYC ((`BNR_ADDR_ACCESS_NS * `BNR_CLK_MHZ) / 1000)

`endif

// ---- core/bnr_pkg.sv ----
package bnr_pkg;

   // Host side of the byte-wide asynchronous port
   typedef struct packed {
      logic chip_sel_n;
      logic out_en_n;
      logic wr_en_n;
      logic [18:0] addr;
      logic [7:0] dq_in;
   } bnr_bus_s;

   // Eight clock register bytes, index 0 is the century byte
   typedef logic [7:0][7:0] bnr_regs_t;

endpackage : bnr_pkg

// ---- core/bnr_rtc.sv ----
`timescale 1ns/1ps
`include "bnr_regs.svh"

// Summary of operation
// - Century byte: bit7 write control, bit6 read control, BCD 00-39.
// - Seconds byte: bit7 oscillator stop, BCD seconds 00-59 below it.
// - Day byte: bit7 battery good, bit6 frequency test, weekday 01-07.
// - Year, month, date, hour, minutes in BCD at 7FFFF down to 7FFFA.
// - Unassigned clock register bits are plain read/write storage.
// - Read when chip select and output enable low, write enable high.
// - Data pins driven only with chip select and output enable active.
// - Write while select and write enable low; data at overlap end kept.
// - Write enable falling with output enable low turns data drive off.
// - Power fail blocks every read and write of registers and RAM.
// - Open-drain reset pulled low for as long as power fail lasts.
// - Battery good flag ignores writes, reads one unless battery spent.
// - Counters and RAM are kept intact while on backup power.
// - Read control freezes visible time; counting goes on underneath.
// - Write control halts updates; clearing it loads the counters.
// - Oscillator stop bit halts all counting until written back to 0.
// - Frequency test toggles seconds LSB at 512 Hz while running.
module bnr_rtc
   import bnr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Host port pins
   input bnr_bus_s host,
   output logic [7:0] dq_out,
   output logic dq_oe_n,
   // Supply and battery monitors
   input wire logic power_fail,
   input wire logic battery_exhausted,
   // Oscillator tick, one pulse per oscillator period
   input wire logic osc_tick,
   // Open-drain reset pin
   output logic reset_pin_out,
   output logic reset_pin_oe_n
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // BCD byte to binary
   function automatic logic [6:0] bcd2bin(input logic [7:0] b);
      logic [7:0] v;
      v = 8'(b[7:4] * 4'hA) + {4'h0, b[3:0]};
      return v[6:0];
   endfunction : bcd2bin

   // BCD increment of one byte
   function automatic logic [7:0] bcd_inc(input logic [7:0] b);
      if (b[3:0] >= 4'h9) begin
         return {4'(b[7:4] + 4'h1), 4'h0};
      end
      return {b[7:4], 4'(b[3:0] + 4'h1)};
   endfunction : bcd_inc

   // Full decode of the clock register window, used by read and write
   function automatic logic clk_window(input logic [18:0] a);
      return a[18:3] == `BNR_CLK_BASE_HI;
   endfunction : clk_window

   // Last date of a month, in BCD
   function automatic logic [7:0] month_len(input logic [7:0] m,
                                            input logic leap);
      case (m)
         8'h02: month_len = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
         default: month_len = 8'h31;
      endcase
   endfunction : month_len

   // One-second advance of the whole calendar
   function automatic bnr_regs_t bnr_advance(input bnr_regs_t t);
      bnr_regs_t n;
      logic [6:0] yb;
      logic [6:0] cb;
      logic leap;
      n = t;
      yb = bcd2bin(t[`BNR_IDX_YEAR]);
      cb = bcd2bin(t[`BNR_IDX_CENT]);
      // Year 00 is a leap year only when the century divides by four
      leap = (yb[1:0] == 2'h0) && ((yb != 7'h0) || (cb[1:0] == 2'h0));
      if (t[`BNR_IDX_SEC] < 8'h59) begin
         n[`BNR_IDX_SEC] = bcd_inc(t[`BNR_IDX_SEC]);
      end else begin
         n[`BNR_IDX_SEC] = 8'h00;
         if (t[`BNR_IDX_MIN] < 8'h59) begin
            n[`BNR_IDX_MIN] = bcd_inc(t[`BNR_IDX_MIN]);
         end else begin
            n[`BNR_IDX_MIN] = 8'h00;
            if (t[`BNR_IDX_HOUR] < 8'h23) begin
               n[`BNR_IDX_HOUR] = bcd_inc(t[`BNR_IDX_HOUR]);
            end else begin
               n[`BNR_IDX_HOUR] = 8'h00;
               // Weekday wraps 07 to 01, independent of the date
               n[`BNR_IDX_DAY] = (t[`BNR_IDX_DAY] >= 8'h07) ? 8'h01 :
                                 bcd_inc(t[`BNR_IDX_DAY]);
               if (t[`BNR_IDX_DATE] <
                   month_len(t[`BNR_IDX_MON], leap)) begin
                  n[`BNR_IDX_DATE] = bcd_inc(t[`BNR_IDX_DATE]);
               end else begin
                  n[`BNR_IDX_DATE] = 8'h01;
                  if (t[`BNR_IDX_MON] < 8'h12) begin
                     n[`BNR_IDX_MON] = bcd_inc(t[`BNR_IDX_MON]);
                  end else begin
                     n[`BNR_IDX_MON] = 8'h01;
                     if (t[`BNR_IDX_YEAR] < 8'h99) begin
                        n[`BNR_IDX_YEAR] = bcd_inc(t[`BNR_IDX_YEAR]);
                     end else begin
                        n[`BNR_IDX_YEAR] = 8'h00;
                        n[`BNR_IDX_CENT] =
                           (t[`BNR_IDX_CENT] >= 8'h39) ? 8'h00 :
                           bcd_inc(t[`BNR_IDX_CENT]);
                     end
                  end
               end
            end
         end
      end
      return n;
   endfunction : bnr_advance

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------

   // Whole array; its top eight bytes are shadowed by the clock registers
   logic [7:0] ram [0:524287];
   bnr_regs_t user;         // Host-visible clock registers
   bnr_regs_t cnt;          // Running counters, counting fields only
   bnr_regs_t field_mask;
   logic [9:0] sub_count;
   logic ft_phase;
   logic wr_ctl_q;
   // Write shadow: last address and data seen in the overlap
   logic wr_act_q;
   logic [18:0] wr_addr_q;
   logic [7:0] wr_data_q;

   // ----------------------------------------------------------------
   // Decode and control bits
   // ----------------------------------------------------------------

   // Which bits of each byte count time; all others are storage
   assign field_mask = {`BNR_MASK_YEAR, `BNR_MASK_MON, `BNR_MASK_DATE,
                        `BNR_MASK_DAY, `BNR_MASK_HOUR, `BNR_MASK_MIN,
                        `BNR_MASK_SEC, `BNR_MASK_CENT};

   wire is_clk_addr = clk_window(host.addr);
   wire [2:0] reg_idx = host.addr[2:0];
   wire wr_ctl = user[`BNR_IDX_CENT][`BNR_BIT_WRITE];
   wire rd_ctl = user[`BNR_IDX_CENT][`BNR_BIT_READ];
   wire osc_stop = user[`BNR_IDX_SEC][`BNR_BIT_OSC_STOP];
   wire freq_test = user[`BNR_IDX_DAY][`BNR_BIT_FREQ_TEST];

   // Counters take the loaded time one cycle after the write bit clears
   wire load_cnt = wr_ctl_q & ~wr_ctl;
   // View holds through that load, else the old time would flash back
   wire copy_en = ~rd_ctl & ~wr_ctl & ~wr_ctl_q;

   // Access modes; power fail deselects everything
   wire selected = ~host.chip_sel_n & ~power_fail;
   wire rd_act = selected & ~host.out_en_n & host.wr_en_n;
   wire wr_act = selected & ~host.wr_en_n;
   // Data latched on the last cycle of the overlap is stored
   wire wr_commit = wr_act_q & ~wr_act & ~power_fail;
   wire wr_clk_reg = wr_commit & clk_window(wr_addr_q);
   wire [2:0] wr_idx = wr_addr_q[2:0];

   // Second tick from the oscillator, gated by the stop bit
   wire osc_run = osc_tick & ~osc_stop;
   wire sec_tick = osc_run &
                   (sub_count == 10'(`BNR_TICKS_PER_SEC - 1));

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------

   // Drive only during a read; write enable falling releases the bus
   assign dq_oe_n = ~rd_act;
   // Reset pin only ever pulls low while power has failed
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe_n = ~power_fail;

   // Byte as the host sees it, flag and test bit overlaid
   logic [7:0] reg_view;
   always_comb begin
      reg_view = user[reg_idx];
      if (reg_idx == `BNR_IDX_DAY) begin
         reg_view[`BNR_BIT_BATT_GOOD] = ~battery_exhausted;
      end
      // Test phase alters only the view; stored seconds stay exact
      if (reg_idx == `BNR_IDX_SEC) begin
         reg_view[`BNR_BIT_FT_LSB] = reg_view[`BNR_BIT_FT_LSB] ^
                                     ft_phase;
      end
   end

   // ----------------------------------------------------------------
   // Host port
   // ----------------------------------------------------------------

   // Read data follows the address every cycle of a read, one address access
   // A one-clock lag stands in for the access time; no handshake
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dq_out <= 8'h00;
      end else if (rd_act) begin
         dq_out <= is_clk_addr ? reg_view : ram[host.addr];
      end
   end

   // Capture address and data while the write overlap lasts
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_act_q <= 1'b0;
         wr_addr_q <= 19'h00000;
         wr_data_q <= 8'h00;
      end else begin
         wr_act_q <= wr_act;
         if (wr_act) begin
            wr_addr_q <= host.addr;
            wr_data_q <= host.dq_in;
         end
      end
   end

   // RAM keeps its contents across reset and backup operation
   always_ff @(posedge clk) begin
      if (wr_commit && !wr_clk_reg) begin
         ram[wr_addr_q] <= wr_data_q;
      end
   end

   // ----------------------------------------------------------------
   // Visible registers
   // ----------------------------------------------------------------

   // Copy counters in unless read or write control holds them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         user <= `BNR_RESET_IMAGE;
      end else begin
         if (copy_en) begin
            for (int i = 0; i < 8; i++) begin
               user[i] <= (user[i] & ~field_mask[i]) |
                          (cnt[i] & field_mask[i]);
            end
         end
         if (wr_clk_reg) begin
            // Flag bit is overlaid on read, so storing it is harmless
            user[wr_idx] <= wr_data_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Timekeeping
   // ----------------------------------------------------------------

   // Sub-second divider and 512 Hz test phase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sub_count <= 10'h000;
         ft_phase <= 1'b0;
      end else begin
         if (osc_run) begin
            sub_count <= sub_count + 10'h001;
         end
         if (!freq_test) begin
            ft_phase <= 1'b0;
         end else if (osc_run) begin
            ft_phase <= ~ft_phase;
         end
      end
   end

   // Counters load on write control release, else count seconds
   // Divider runs on across a load, so the first second may be short
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= `BNR_RESET_IMAGE;
         wr_ctl_q <= 1'b0;
      end else begin
         wr_ctl_q <= wr_ctl;
         if (load_cnt) begin
            for (int i = 0; i < 8; i++) begin
               cnt[i] <= user[i] & field_mask[i];
            end
         end else if (sec_tick) begin
            cnt <= bnr_advance(cnt);
         end
      end
   end

endmodule : bnr_rtc

// ---- tb/bnr_rtc_assertions.sv ----
`timescale 1ns/1ps
module bnr_rtc_assertions
   import bnr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Host port
   input bnr_bus_s host,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe_n,
   // Supply, battery and reset pin
   input wire logic power_fail,
   input wire logic battery_exhausted,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------
   // Bus decode and write shadow
   // ---------------------------------------------
   wire sel = !host.chip_sel_n && !power_fail;
   wire rd_act = sel && !host.out_en_n && host.wr_en_n;
   wire wr_act = sel && !host.wr_en_n;
   wire ram_sel = host.addr[18:3] != 16'hFFFF;
   logic w_ok;
   logic [18:0] w_addr;
   logic [7:0] w_dat;
   // Last RAM write only; clock bytes move on their own, so skipped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         w_ok <= 1'b0;
         w_addr <= 19'h00000;
         w_dat <= 8'h00;
      end else if (wr_act && ram_sel) begin
         w_ok <= 1'b1;
         w_addr <= host.addr;
         w_dat <= host.dq_in;
      end
   end
   // ---------------------------------------------
   // Port checks
   // ---------------------------------------------
   oe_drive_a: assert property (dq_oe_n == !rd_act)
      else $error("Data drive state is wrong");
   we_release_a: assert property (!host.wr_en_n |-> dq_oe_n)
      else $error("Data driven while write enable low");
   pf_block_a: assert property (power_fail |-> dq_oe_n ##1 $stable(dq_out))
      else $error("Access seen during power fail");
   rst_pin_a: assert property (reset_pin_oe_n == !power_fail && !reset_pin_out)
      else $error("Reset pin does not follow power fail");
   read_hold_a: assert property (!rd_act |=> $stable(dq_out))
      else $error("Read data moved with no read");
   ram_rdback_a: assert property (w_ok && rd_act && ram_sel &&
      host.addr == w_addr |=> dq_out == $past(w_dat))
      else $error("RAM read back differs from last write");
   batt_flag_a: assert property (rd_act && host.addr == 19'h7FFFC
      |=> dq_out[7] == !$past(battery_exhausted))
      else $error("Battery flag wrong");
   sec_range_a: assert property (rd_act && host.addr == 19'h7FFF9
      |=> dq_out[6:4] <= 3'h5 && dq_out[3:0] <= 4'h9)
      else $error("Seconds out of range");
   // Main scenarios reached
   cover property (rd_act && !ram_sel);
   cover property (wr_act && ram_sel);
   cover property (power_fail && !host.chip_sel_n);
endmodule : bnr_rtc_assertions

// ---- tb/bnr_host_model.sv ----
`timescale 1ns/1ps
module bnr_host_model
   import bnr_pkg::*;
(
   // Clock
   input wire logic clk,
   // Bus pins
   output bnr_bus_s host,
   input wire logic [7:0] dq_out
);
   // Idle: deselected, address zero, data lines all ones
   initial begin
      host = {3'b111, 19'h00000, 8'hFF};
   end
   // Control is {chip_sel_n, out_en_n, wr_en_n}, changed after negedge
   task automatic drive(input logic [2:0] c, input logic [18:0] a);
      @(negedge clk);
      host = {c, a, ~host.dq_in};
   endtask : drive
   // Output enable stays high; address held past the commit edge
   task automatic wr(input logic [18:0] a, input logic [7:0] d);
      @(negedge clk);
      host = {3'b010, a, d};
      drive(3'b111, a);
      @(negedge clk);
   endtask : wr
   // Data is taken one cycle after the read is driven
   task automatic rd(input logic [18:0] a, output logic [7:0] d);
      drive(3'b001, a);
      @(negedge clk);
      d = dq_out;
      drive(3'b111, a);
   endtask : rd
endmodule : bnr_host_model

// ---- tb/tb_bnr_rtc.sv ----
`timescale 1ns/1ps
module tb_bnr_rtc
   import bnr_pkg::*;
;
   logic clk, reset_n, power_fail, battery_exhausted, osc_tick;
   logic [7:0] dq_out, v, s0;
   logic dq_oe_n, reset_pin_out, reset_pin_oe_n;
   bnr_bus_s host;
   int bad_count = 0;
   int num_checks = 0;
   // ---------------------------------------------
   // Device and host
   // ---------------------------------------------
   bnr_rtc u_bnr_rtc (.clk(clk), .reset_n(reset_n), .host(host),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .power_fail(power_fail),
      .battery_exhausted(battery_exhausted), .osc_tick(osc_tick),
      .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));
   bnr_host_model u_host (.clk(clk), .host(host), .dq_out(dq_out));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask : chk
   task automatic rchk(string n, logic [18:0] a, logic [7:0] e);
      u_host.rd(a, v);
      chk(n, e, v);
   endtask : rchk
   // One-cycle tick pulses, one idle cycle apart
   task automatic tick(int n);
      repeat (n) begin
         @(negedge clk);
         osc_tick = 1'b1;
         @(negedge clk);
         osc_tick = 1'b0;
      end
   endtask : tick
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      logic [63:0] img = 64'h00_01_01_81_00_00_00_00;
      for (int i = 0; i < 8; i++) begin
         rchk("reset reg", 19'(19'h7FFF8 + i), img[i*8 +: 8]);
      end
      battery_exhausted = 1'b1;
      rchk("spent flag", 19'h7FFFC, 8'h01);
      battery_exhausted = 1'b0;
      u_host.wr(19'h00000, 8'hA5);
      u_host.wr(19'h7FFF7, 8'h3C);
      rchk("ram low", 19'h00000, 8'hA5);
      rchk("ram top", 19'h7FFF7, 8'h3C);
      rchk("century", 19'h7FFF8, 8'h00);
      $display("test reset and ram done");
   endtask : t_reset
   // Load Feb 28, 23:59:59 of a non-leap year, then one second
   task automatic t_set();
      logic [63:0] w = 64'h01_02_28_3A_23_59_59_80;
      logic [63:0] e = 64'h01_03_01_BB_00_00_00_20;
      for (int i = 0; i < 8; i++) begin
         u_host.wr(19'(19'h7FFF8 + i), w[i*8 +: 8]);
      end
      u_host.wr(19'h7FFF8, 8'h20);
      rchk("day bits", 19'h7FFFC, 8'hBA);
      tick(1024);
      for (int i = 0; i < 8; i++) begin
         rchk("rollover", 19'(19'h7FFF8 + i), e[i*8 +: 8]);
      end
      $display("test set clock done");
   endtask : t_set
   task automatic t_stop_freeze();
      u_host.wr(19'h7FFF8, 8'hA0);
      u_host.wr(19'h7FFF9, 8'h90);
      u_host.wr(19'h7FFF8, 8'h20);
      tick(1024);
      rchk("stopped", 19'h7FFF9, 8'h90);
      u_host.wr(19'h7FFF8, 8'hA0);
      u_host.wr(19'h7FFF9, 8'h10);
      u_host.wr(19'h7FFF8, 8'h20);
      u_host.wr(19'h7FFF8, 8'h60);
      tick(1024);
      rchk("frozen", 19'h7FFF9, 8'h10);
      u_host.wr(19'h7FFF8, 8'h20);
      rchk("released", 19'h7FFF9, 8'h11);
      $display("test stop and freeze done");
   endtask : t_stop_freeze
   task automatic t_freq();
      u_host.wr(19'h7FFF8, 8'hA0);
      u_host.wr(19'h7FFFC, 8'h7B);
      u_host.wr(19'h7FFF8, 8'h20);
      u_host.rd(19'h7FFF9, s0);
      chk("test bit off", 8'h11, s0);
      tick(1);
      rchk("test bit", 19'h7FFF9, 8'h10);
      $display("test frequency done");
   endtask : t_freq
   task automatic t_pins();
      power_fail = 1'b1;
      u_host.wr(19'h00000, 8'h5A);
      u_host.drive(3'b001, 19'h00000);
      #1;
      chk("pf drive", 8'h01, {7'h00, dq_oe_n});
      chk("pf pin", 8'h00, {7'h00, reset_pin_oe_n});
      u_host.drive(3'b111, 19'h00000);
      power_fail = 1'b0;
      rchk("kept", 19'h00000, 8'hA5);
      chk("pin off", 8'h01, {7'h00, reset_pin_oe_n});
      u_host.drive(3'b001, 19'h7FFF7);
      #1;
      chk("rd drive", 8'h00, {7'h00, dq_oe_n});
      u_host.drive(3'b000, 19'h7FFF7);
      #1;
      chk("we off", 8'h01, {7'h00, dq_oe_n});
      u_host.drive(3'b111, 19'h7FFF7);
      $display("test pins done");
   endtask : t_pins
   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
   initial begin
      reset_n = 1'b0;
      power_fail = 1'b0;
      battery_exhausted = 1'b0;
      osc_tick = 1'b0;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      t_reset();
      t_set();
      t_stop_freeze();
      t_freq();
      t_pins();
      report_and_stop();
   end
endmodule : tb_bnr_rtc
bind bnr_rtc bnr_rtc_assertions u_chk (.clk(clk), .reset_n(reset_n),
   .host(host), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
   .power_fail(power_fail), .battery_exhausted(battery_exhausted),
   .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));
